// ===== rtcs_host.sv
`include "rtcs_consts.svh"
module rtcs_host
    import rtcs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       cmdValid,
    input  wire logic       cmdRead,
    input  wire logic [3:0] cmdAddr,
    input  wire logic [3:0] cmdData,
    input  wire logic       cmdLast,
    input  wire logic       variantB,
    output logic            cmdReady,
    output logic            rspValid,
    output logic [3:0]      rspData,
    output logic            chipSelect,
    output logic            shiftClk,
    output logic            serialOut,
    output logic            serialOe_n,
    input  wire logic       serialIn
);
    rtcs_state_t state_r, state_nxt;
    logic [3:0]  div_r, div_nxt;
    logic [3:0]  bit_r, bit_nxt;
    logic [1:0]  byteIdx_r, byteIdx_nxt;
    logic [7:0]  txByte_r, txByte_nxt;
    logic [3:0]  rxData_r, rxData_nxt;
    logic        isRead_r, isRead_nxt;
    logic [3:0]  addr_r, addr_nxt;
    logic [3:0]  data_r, data_nxt;
    logic        last_r, last_nxt;
    logic        cmdReady_r, cmdReady_nxt;
    logic        rspValid_r, rspValid_nxt;
    logic [3:0]  rspData_r, rspData_nxt;
    logic        cs_r, cs_nxt;
    logic        sclk_r, sclk_nxt;
    logic        sOut_r, sOut_nxt;
    logic        sOe_n_r, sOe_n_nxt;
    logic        inMeta_r, inSync_r;
    logic        sampleEdge;
    logic        take;
    logic        launchEdge;

    // serialIn comes from the pin; two flops before use
    always_ff @(posedge clk)
    begin
        inMeta_r <= serialIn;
        inSync_r <= inMeta_r;
    end

    // host drives the clock; idle level is low for A, high for B
    // (pin level of B's inverted clock); the pulse edges swap accordingly
    assign launchEdge = (div_r == `RTCS_HALF_PERIOD);

    always_comb
    begin
        state_nxt    = state_r;
        div_nxt      = div_r;
        bit_nxt      = bit_r;
        byteIdx_nxt  = byteIdx_r;
        txByte_nxt   = txByte_r;
        cs_nxt       = cs_r;
        sclk_nxt     = sclk_r;
        sOut_nxt     = sOut_r;
        sOe_n_nxt    = sOe_n_r;
        sampleEdge   = 1'b0;
        take         = 1'b0;
        unique case (state_r)
            RTCS_IDLE:
            begin
                sclk_nxt = variantB;
                if (cmdValid && !cmdReady_r)
                begin
                    take         = 1'b1;
                    txByte_nxt   = {(cmdRead ? `RTCS_CMD_READ
                                             : `RTCS_CMD_ADDR_WR), cmdAddr};
                    byteIdx_nxt  = 2'h0;
                    bit_nxt      = 4'h0;
                    div_nxt      = 4'h0;
                    if (!cs_r)
                    begin
                        cs_nxt    = 1'b1;
                        state_nxt = RTCS_SETUP;
                    end
                    else
                    begin
                        state_nxt = RTCS_LOW;
                    end
                end
            end
            RTCS_SETUP:
            begin
                div_nxt = div_r + 4'h1;
                if (div_r == `RTCS_SETUP_CYC)
                begin
                    div_nxt   = 4'h0;
                    state_nxt = RTCS_LOW;
                end
            end
            RTCS_LOW:
            begin
                div_nxt = div_r + 4'h1;
                if (launchEdge)
                begin
                    // leading edge: rising for A, falling for B
                    div_nxt   = 4'h0;
                    sclk_nxt  = !variantB;
                    sOut_nxt  = txByte_r[7];
                    // released before the device drives at 2B
                    // pin taken back only once 1C has begun
                    sOe_n_nxt = isRead_r && byteIdx_r == 2'h1;
                    state_nxt = RTCS_HIGH;
                end
            end
            RTCS_HIGH:
            begin
                div_nxt = div_r + 4'h1;
                if (launchEdge)
                begin
                    // trailing edge for B is rising
                    sampleEdge = 1'b1;
                    div_nxt    = 4'h0;
                    sclk_nxt   = variantB;
                    txByte_nxt = {txByte_r[6:0], 1'b0};
                    bit_nxt    = bit_r + 4'h1;
                    state_nxt  = RTCS_LOW;
                    if (bit_r == 4'h7)
                    begin
                        bit_nxt = 4'h0;
                        byteIdx_nxt = byteIdx_r + 2'h1;
                        if (byteIdx_r == 2'h0)
                        begin
                            // read second byte carries no load
                            txByte_nxt = isRead_r ? 8'h00
                                       : {`RTCS_CMD_DATA_WR, data_r};
                        end
                        else
                        begin
                            div_nxt   = 4'h0;
                            state_nxt = last_r ? RTCS_HOLD : RTCS_IDLE;
                        end
                    end
                end
            end
            RTCS_HOLD:
            begin
                div_nxt = div_r + 4'h1;
                if (div_r == 4'(`RTCS_HOLD_CYC))
                begin
                    cs_nxt    = 1'b0;
                    sOe_n_nxt = 1'b1;
                    state_nxt = RTCS_IDLE;
                end
            end
            default:
                state_nxt = RTCS_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r    <= RTCS_IDLE;
            div_r      <= 4'h0;
            bit_r      <= 4'h0;
            byteIdx_r  <= 2'h0;
            txByte_r   <= 8'h00;
            cs_r       <= 1'b0;
            sclk_r     <= 1'b0;
            sOut_r     <= 1'b0;
            sOe_n_r    <= 1'b1;
        end
        else
        begin
            state_r    <= state_nxt;
            div_r      <= div_nxt;
            bit_r      <= bit_nxt;
            byteIdx_r  <= byteIdx_nxt;
            txByte_r   <= txByte_nxt;
            cs_r       <= cs_nxt;
            sclk_r     <= sclk_nxt;
            sOut_r     <= sOut_nxt;
            sOe_n_r    <= sOe_n_nxt;
        end
    end

    // request group: one accepted request at a time
    // direction bit kept per transaction
    always_comb
    begin
        cmdReady_nxt = take;
        isRead_nxt   = isRead_r;
        addr_nxt     = addr_r;
        data_nxt     = data_r;
        last_nxt     = last_r;
        if (take)
        begin
            isRead_nxt = cmdRead;
            addr_nxt   = cmdAddr;
            data_nxt   = cmdData;
            last_nxt   = cmdLast;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cmdReady_r <= 1'b0;
            isRead_r   <= 1'b0;
            addr_r     <= 4'h0;
            data_r     <= 4'h0;
            last_r     <= 1'b0;
        end
        else
        begin
            cmdReady_r <= cmdReady_nxt;
            isRead_r   <= isRead_nxt;
            addr_r     <= addr_nxt;
            data_r     <= data_nxt;
            last_r     <= last_nxt;
        end
    end

    // receive group: the synchronised pin lags two clocks, well inside
    // the four-clock half period, so the trailing edge still sees the bit
    always_comb
    begin
        rxData_nxt   = rxData_r;
        rspValid_nxt = 1'b0;
        rspData_nxt  = rspData_r;
        // device data settles before the trailing edge
        // read nibble on pulses five to eight
        if (sampleEdge && isRead_r && byteIdx_r == 2'h1 && bit_r >= 4'h4)
        begin
            rxData_nxt = {rxData_r[2:0], inSync_r};
            if (bit_r == 4'h7)
            begin
                rspValid_nxt = 1'b1;
                rspData_nxt  = {rxData_r[2:0], inSync_r};
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rxData_r   <= 4'h0;
            rspValid_r <= 1'b0;
            rspData_r  <= 4'h0;
        end
        else
        begin
            rxData_r   <= rxData_nxt;
            rspValid_r <= rspValid_nxt;
            rspData_r  <= rspData_nxt;
        end
    end

    assign cmdReady   = cmdReady_r;
    assign rspValid   = rspValid_r;
    assign rspData    = rspData_r;
    assign chipSelect = cs_r;
    assign shiftClk   = sclk_r;
    assign serialOut  = sOut_r;
    assign serialOe_n = sOe_n_r;
endmodule // rtcs_host

// ===== rtcs_consts.svh
`ifndef RTCS_CONSTS_SVH
`define RTCS_CONSTS_SVH
// link clock half period in system clocks, less one (100 ns each)
`define RTCS_HALF_PERIOD   4'h3
// select hold time, ns, and its count of system clocks (least: round up)
`define RTCS_HOLD_NS       200
`define RTCS_HOLD_CYC      ((`RTCS_HOLD_NS + 99) / 100)
// select setup before first edge, in system clocks
`define RTCS_SETUP_CYC     4'h2
// control nibble bit positions (bit 3 ignored by the device)
`define RTCS_DIR_POS       2
`define RTCS_ALD_POS       1
`define RTCS_DLD_POS       0
`define RTCS_CMD_READ      4'h6
`define RTCS_CMD_ADDR_WR   4'h2
`define RTCS_CMD_DATA_WR   4'h1
`define RTCS_CMD_END       4'h0
`endif

// ===== rtcs_pkg.sv
package rtcs_pkg;
    typedef enum logic [2:0] {
        RTCS_IDLE,
        RTCS_SETUP,
        RTCS_LOW,
        RTCS_HIGH,
        RTCS_HOLD
    } rtcs_state_t;
endpackage

// ===== rtcs_host_sva.sv
module rtcs_host_sva (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       cmdValid,
    input wire logic       cmdRead,
    input wire logic [3:0] cmdAddr,
    input wire logic [3:0] cmdData,
    input wire logic       variantB,
    input wire logic       cmdReady,
    input wire logic       rspValid,
    input wire logic       chipSelect,
    input wire logic       shiftClk,
    input wire logic       serialOut,
    input wire logic       serialOe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       clkQ_r, outQ_r, trail;
    logic [3:0] cnt_r;
    logic [7:0] shf_r;
    logic [8:0] pend_r, cur_r;
    // the data bit is taken from before the edge: it may move with the edge
    assign trail = chipSelect && clkQ_r != shiftClk && shiftClk == variantB;
    always_ff @(posedge clk)
    begin
        clkQ_r <= shiftClk;
        outQ_r <= serialOut;
        if (trail)
            shf_r <= {shf_r[6:0], outQ_r};
        cnt_r <= (sys_rst || !chipSelect) ? 4'h0 : cnt_r + 4'(trail);
        if (cmdValid)
            pend_r <= {cmdRead, cmdAddr, cmdData};
        if (cmdReady)
            cur_r <= pend_r;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_still;
        $stable(shiftClk) [*3];
    endsequence
    property p_half;
        chipSelect && $changed(shiftClk) |=> s_still;
    endproperty
    a_half: assert property (p_half) else $error("short clock phase");
    property p_byteA;
        trail && cnt_r == 4'h7 |=> shf_r == {1'b0, cur_r[8], 2'b10, cur_r[7:4]};
    endproperty
    a_byteA: assert property (p_byteA) else $error("bad byte A");
    property p_byteB;
        trail && cnt_r == 4'hf && !cur_r[8] |=> shf_r == {4'h1, cur_r[3:0]};
    endproperty
    a_byteB: assert property (p_byteB) else $error("bad byte B");
    property p_release;
        cur_r[8] && cnt_r > 4'h8 |-> serialOe_n;
    endproperty
    a_release: assert property (p_release) else $error("pin held");
    property p_rsp;
        rspValid |-> cur_r[8] && trail && cnt_r == 4'hf;
    endproperty
    a_rsp: assert property (p_rsp) else $error("stray response");
    property p_hold;
        $fell(chipSelect) |-> !$past(trail) && $past(cnt_r) == 4'h0;
    endproperty
    a_hold: assert property (p_hold) else $error("early deselect");
    property p_idleOe;
        !chipSelect && !$past(chipSelect) |-> serialOe_n;
    endproperty
    a_idleOe: assert property (p_idleOe) else $error("drives idle pin");
    property p_idleClk;
        !chipSelect [*3] ##0 $stable(variantB) |-> shiftClk == variantB;
    endproperty
    a_idleClk: assert property (p_idleClk) else $error("idle clock");
endmodule // rtcs_host_sva

bind rtcs_host rtcs_host_sva chk (.clk(clk), .sys_rst(sys_rst),
    .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .variantB(variantB), .cmdReady(cmdReady),
    .rspValid(rspValid), .chipSelect(chipSelect), .shiftClk(shiftClk),
    .serialOut(serialOut), .serialOe_n(serialOe_n));

// ===== rtcs_dev_model.sv
module rtcs_dev_model (
    input  wire logic chipSelect,
    input  wire logic shiftClk,
    input  wire logic variantB,
    input  wire logic sioIn,
    output logic      sioOut,
    output logic      sioEn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] mem [16];
    logic [3:0] addr = 4'h0;
    logic [3:0] cnt = 4'h0;
    logic [7:0] shf = 8'h00;
    logic       rd = 1'b0;
    initial
    begin
        sioOut = 1'b0;
        sioEn = 1'b0;
        foreach (mem[i]) mem[i] = 4'h0;
    end
    always @(chipSelect)
    begin
        cnt = 4'h0;
        sioEn = 1'b0;
    end
    always @(shiftClk)
    begin
        if (chipSelect && shiftClk == variantB)
        begin
            shf = {shf[6:0], sioIn};
            if (cnt == 4'h7 && shf[5] && !shf[4])
                addr = shf[3:0];
            if (cnt == 4'h7)
                rd = shf[6];
            if (cnt == 4'hf && !shf[6] && shf[4] && !shf[5])
                mem[addr] = shf[3:0];
            cnt = cnt + 4'h1;
        end
        else if (chipSelect)
        begin
            sioEn = (cnt == 4'h9 && rd) || (sioEn && cnt != 4'h0);
            sioOut = cnt > 4'hb ? mem[addr][4'hf - cnt] : ~sioOut;
        end
    end
endmodule // rtcs_dev_model

// ===== rtcs_host_tb.sv
module rtcs_host_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       cmdValid = 1'b0;
    logic       cmdRead = 1'b0;
    logic       cmdLast = 1'b1;
    logic       variantB = 1'b0;
    logic [3:0] cmdAddr = 4'h0;
    logic [3:0] cmdData = 4'h0;
    logic [3:0] rspData;
    logic       cmdReady, rspValid, chipSelect, shiftClk, serialOut;
    logic       serialOe_n, devOut, devEn, serial_data_pin, sioMid;
    logic [3:0] shadow [16];
    int         err_count = 0;
    int         compares = 0;
    always #50 clk = ~clk;
    // a released pin shows the inverse: no pull on this line
    assign serial_data_pin = devEn ? devOut : serialOut ^ serialOe_n;
    always @(negedge clk) sioMid = serial_data_pin;
    rtcs_host dut (.clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid),
        .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .cmdLast(cmdLast), .variantB(variantB), .cmdReady(cmdReady),
        .rspValid(rspValid), .rspData(rspData), .chipSelect(chipSelect),
        .shiftClk(shiftClk), .serialOut(serialOut),
        .serialOe_n(serialOe_n), .serialIn(serial_data_pin));
    rtcs_dev_model dev (.chipSelect(chipSelect), .shiftClk(shiftClk),
        .variantB(variantB), .sioIn(sioMid), .sioOut(devOut), .sioEn(devEn));
    task automatic results();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tmo();
        err_count++;
        $display("[FAIL] %0t handshake timed out", $time);
        results();
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic rd, input logic [3:0] a,
                        input logic [3:0] d, input logic last);
        int i;
        @(negedge clk);
        {cmdValid, cmdRead, cmdAddr, cmdData, cmdLast} = {1'b1, rd, a, d, last};
        for (i = 0; i < 400 && cmdReady !== 1'b1; i++)
            @(negedge clk);
        if (cmdReady !== 1'b1)
            tmo();
        cmdValid = 1'b0;
        if (!rd)
            shadow[a] = d;
        for (i = 0; rd && i < 400 && rspValid !== 1'b1; i++)
            @(negedge clk);
        if (rd && rspValid !== 1'b1)
            tmo();
        if (rd)
            chk(rspData, shadow[a]);
    endtask
    initial
    begin
        int v, n;
        void'($urandom(34063));
        repeat (6) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        for (v = 0; v < 2; v++)
        begin
            variantB = v[0];
            for (n = 0; n < 16; n++)
                xfer(1'b0, n[3:0], 4'($urandom), 1'($urandom));
            xfer(1'b0, 4'h9, 4'h0, 1'b0);
            xfer(1'b1, 4'h9, 4'h0, 1'b0);
            xfer(1'b0, 4'h9, 4'hf, 1'b0);
            for (n = 0; n < 24; n++)
                xfer(1'($urandom), 4'($urandom), 4'($urandom), 1'($urandom));
            xfer(1'b1, 4'h9, 4'h0, 1'b1);
            for (n = 0; n < 50 && chipSelect; n++)
                @(negedge clk);
            if (chipSelect)
                tmo();
            @(negedge clk);
        end
        results();
    end
endmodule // rtcs_host_tb
